/* include/lics_pkg.sv */
// Purpose: Shared constants for the line interface control/status block
// Assumes: Registers are 8 bits wide, one per 32-bit APB word
// Notes: Byte address of a register is four times its index
package lics_pkg;
   localparam int ADDR_W = 8;
   localparam logic [5:0] IDX_INFO = 6'h11;
   localparam logic [5:0] IDX_STATUS = 6'h14;
   localparam logic [5:0] IDX_MASK = 6'h15;
   localparam logic [5:0] IDX_LINE_INTERFACE_CONTROL_TWO = 6'h31;
   localparam logic [5:0] IDX_LINE_INTERFACE_CONTROL_THREE = 6'h32;
   localparam logic [5:0] IDX_LINE_INTERFACE_CONTROL_FOUR = 6'h33;
   localparam logic [5:0] IDX_TGAIN = 6'h34;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] WMASK_LINE_INTERFACE_CONTROL_TWO = 8'hFB;
   localparam logic [7:0] WMASK_LINE_INTERFACE_CONTROL_THREE = 8'hD9;
   localparam logic [7:0] WMASK_LINE_INTERFACE_CONTROL_FOUR = 8'hFF;
   localparam logic [7:0] WMASK_TGAIN = 8'h7F;
   localparam logic [7:0] WMASK_MASK = 8'h16;
   localparam int B_CUSTOM_DRIVER_SELECT = 0;
   localparam int B_SHORT_LIMIT_DISABLE = 1;
   localparam int B_CKS0 = 3;
   localparam int B_AIS = 4;
   localparam int B_VIOLATION_INSERT = 5;
   localparam int B_LINE_RESET = 6;
   localparam int B_CKS1 = 7;
   localparam int B_ALTERNATING_PATTERN_TX = 0;
   localparam int B_MM_LO = 3;
   localparam int B_CMI_POLARITY_INVERT = 6;
   localparam int B_CMI_MODE_ON = 7;
   localparam int B_RT_LO = 0;
   localparam int B_TT_LO = 3;
   localparam int B_MPS_LO = 6;
   localparam int B_AGC = 6;
   localparam int B_TX_OPEN_CIRCUIT = 1;
   localparam int B_TX_CURRENT_LIMIT = 2;
   localparam int B_ATTENUATOR_TRIP = 4;
   // One-hot: [0] 75 ohm, [1] 100 ohm, [2] 120 ohm, [3] 110 ohm
   function automatic logic [3:0] lics_term_dec(input logic [2:0] code);
      case (code)
         3'h1: lics_term_dec = 4'h1;
         3'h2: lics_term_dec = 4'h2;
         3'h3: lics_term_dec = 4'h4;
         3'h4: lics_term_dec = 4'h8;
         default: lics_term_dec = 4'h0;
      endcase
   endfunction
endpackage

/* include/lics_ctl_if.sv */
// Purpose: Control and line-pin bundle between register bank and encoder
// Assumes: Single clock domain
// Notes: Pins are separate output and enable, no tristate here
`timescale 1ns/1ns
`default_nettype none
interface lics_ctl_if;
   logic ais_n, alt, cmi_on, cmi_inv, custom, bpv_arm;
   logic [2:0] build_out;
   logic pos, pos_oe, neg, neg_oe;
   modport ctl (output ais_n, alt, cmi_on, cmi_inv, custom, bpv_arm, build_out,
      input pos, pos_oe, neg, neg_oe);
   modport enc (input ais_n, alt, cmi_on, cmi_inv, custom, bpv_arm, build_out,
      output pos, pos_oe, neg, neg_oe);
endinterface
`default_nettype wire

/* rtl/lics_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous status pins
// Assumes: Each bit is an independent level
// Notes: Multi-bit codes may tear for one cycle while changing
`timescale 1ns/1ns
`default_nettype none
module lics_sync #(parameter int WIDTH = 7) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   if (WIDTH < 1) begin : g_chk
      $error("lics_sync needs WIDTH of at least 1");
   end
   typedef struct packed {
      logic [WIDTH-1:0] ff1;
      logic [WIDTH-1:0] ff2;
   } lics_sync_s;
   lics_sync_s s, next_s;
   always_comb begin
      next_s = s;
      next_s.ff1 = din;
      next_s.ff2 = s.ff1;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign dout = s.ff2;
endmodule
`default_nettype wire

/* rtl/lics_tx_enc.sv */
// Purpose: Transmit line encoder: AMI, square wave, CMI, AIS, BPV insert
// Assumes: tx_bit_valid at bit start, tx_mid at mid-bit, never together
// Notes: Open-drain mode drives a pin low only while it marks
`timescale 1ns/1ns
`default_nettype none
module lics_tx_enc (
   input wire logic clock,
   input wire logic rst,
   input wire logic tx_bit,
   input wire logic tx_bit_valid,
   input wire logic tx_mid,
   lics_ctl_if.enc lk
);
   typedef struct packed {
      logic pol, armed, alt_q, sq, cmi_lvl, cmi_zero, mp, mn;
      logic [1:0] ones;
      logic pos, pos_oe, neg, neg_oe;
   } lics_enc_s;
   lics_enc_s s, next_s;
   logic one, sq_mode, open_drain;
   assign sq_mode = lk.custom && (lk.build_out == 3'h0);
   assign open_drain = lk.custom && (lk.build_out != 3'h0);
   // Pattern beats alarm, alarm beats data
   assign one = lk.alt ? ~s.alt_q : (lk.ais_n ? tx_bit : 1'b1);
   always_comb begin
      next_s = s;
      if (tx_bit_valid) begin
         next_s.alt_q = ~s.alt_q;
         if (sq_mode) begin
            next_s.sq = ~s.sq;
            next_s.mp = ~s.sq;
            next_s.mn = s.sq;
         end else if (lk.cmi_on) begin
            next_s.cmi_zero = ~one;
            if (one) begin
               next_s.cmi_lvl = ~s.cmi_lvl;
            end
            next_s.mp = (one & ~s.cmi_lvl) ^ lk.cmi_inv;
            next_s.mn = 1'b0;
         end else if (one && s.armed && s.ones == 2'h2) begin
            // Same polarity as the last mark makes the violation
            next_s.armed = 1'b0;
            next_s.ones = 2'h0;
            next_s.mp = s.pol;
            next_s.mn = ~s.pol;
         end else if (one) begin
            next_s.pol = ~s.pol;
            next_s.mp = ~s.pol;
            next_s.mn = s.pol;
            next_s.ones = (s.ones == 2'h3) ? 2'h3 : s.ones + 2'h1;
         end else begin
            next_s.mp = 1'b0;
            next_s.mn = 1'b0;
            next_s.ones = 2'h0;
         end
      end else if (tx_mid && !sq_mode) begin
         // CMI zero rises at mid-bit, or falls with cmi_inv; AMI marks return to zero
         next_s.mp = lk.cmi_on ? (s.cmi_zero ? ~lk.cmi_inv : s.mp) : 1'b0;
         next_s.mn = 1'b0;
      end
      if (lk.bpv_arm) begin
         next_s.armed = 1'b1;
      end
      next_s.pos = open_drain ? 1'b0 : next_s.mp;
      next_s.neg = open_drain ? 1'b0 : next_s.mn;
      next_s.pos_oe = open_drain ? next_s.mp : 1'b1;
      next_s.neg_oe = open_drain ? next_s.mn : 1'b1;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign lk.pos = s.pos;
   assign lk.pos_oe = s.pos_oe;
   assign lk.neg = s.neg;
   assign lk.neg_oe = s.neg_oe;
   AST_BPV_POL: assert property (@(posedge clock) disable iff (rst)
      tx_bit_valid && one && s.armed && s.ones == 2'h2 && !lk.cmi_on
      && !lk.custom |=> lk.pos == $past(s.pol) && !s.armed)
      else $error("violation not inserted with repeated polarity");
   AST_AIS_MARK: assert property (@(posedge clock) disable iff (rst)
      tx_bit_valid && !lk.ais_n && !lk.alt && !lk.cmi_on && !lk.custom
      |=> lk.pos != lk.neg)
      else $error("alarm signal did not send a mark");
endmodule
`default_nettype wire

/* rtl/lics_top.sv */
// Purpose: Line interface control and status registers behind APB
// Assumes: Status pins are asynchronous; transmit data is on clock
// Notes: Zero-wait APB slave, one setup and one access cycle
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module lics_top (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lics_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_bit,
   input wire logic tx_bit_valid,
   input wire logic tx_mid,
   input wire logic [2:0] build_out,
   input wire logic [5:0] agc_gain,
   input wire logic [3:0] rx_level_pin,
   input wire logic tx_open_pin,
   input wire logic tx_limit_pin,
   input wire logic atten_trip_pin,
   output logic tx_line_pos,
   output logic tx_line_pos_oe,
   output logic tx_line_neg,
   output logic tx_line_neg_oe,
   output logic [5:0] tx_gain_level,
   output logic current_limit_on,
   output logic pll_t1_on,
   output logic pll_e1_on,
   output logic [1:0] prescale,
   output logic [1:0] rx_boost_sel,
   output logic line_reset_pulse,
   output logic cmi_mode_on,
   output logic cmi_rx_invert,
   output logic [3:0] rx_term_sel,
   output logic [3:0] tx_term_sel,
   output logic line_irq
);
   typedef struct packed {
      logic [7:0] line_interface_control_two, line_interface_control_three, line_interface_control_four, tgain, mask;
      logic attenuator_trip;
      logic [2:0] pend;
      logic [1:0] cond_q;
      logic trip_q;
      logic rst_pulse, bpv_pulse;
      logic [7:0] rdata;
      logic ready, err, irq, lim_on;
      logic [5:0] gain;
      logic [3:0] rterm, tterm;
   } lics_top_s;
   lics_top_s s, next_s;
   lics_ctl_if lk ();
   logic [6:0] sync_q;
   logic [3:0] level;
   logic open_c, limit_c, trip, trip_rise;
   logic setup, access, wr, rd_status, hit;
   logic [5:0] idx;
   logic [7:0] status, rd_mux, wd;

   lics_sync #(.WIDTH(7)) u_sync (
      .clock(clock),
      .rst(rst),
      .din({atten_trip_pin, tx_limit_pin, tx_open_pin, rx_level_pin}),
      .dout(sync_q)
   );
   lics_tx_enc u_enc (
      .clock(clock),
      .rst(rst),
      .tx_bit(tx_bit),
      .tx_bit_valid(tx_bit_valid),
      .tx_mid(tx_mid),
      .lk(lk.enc)
   );

   assign level = sync_q[3:0];
   assign open_c = sync_q[4];
   assign limit_c = sync_q[5];
   assign trip = sync_q[6];
   assign trip_rise = trip & ~s.trip_q;

   assign idx = paddr[7:2];
   assign wd = pwdata[7:0];
   assign setup = psel & ~penable;
   assign access = psel & penable & s.ready;
   assign wr = access & pwrite & ~s.err;
   assign rd_status = access & ~pwrite & ~s.err & (idx == lics_pkg::IDX_STATUS);

   always_comb begin
      status = 8'h00;
      status[lics_pkg::B_TX_OPEN_CIRCUIT] = open_c;
      status[lics_pkg::B_TX_CURRENT_LIMIT] = limit_c;
      status[lics_pkg::B_ATTENUATOR_TRIP] = s.attenuator_trip;
   end

   always_comb begin
      hit = (paddr[1:0] == 2'h0);
      // Unused bits are never stored, so they read back as zero
      case (idx)
         lics_pkg::IDX_INFO: rd_mux = {4'h0, level};
         lics_pkg::IDX_STATUS: rd_mux = status;
         lics_pkg::IDX_MASK: rd_mux = s.mask;
         lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO: rd_mux = s.line_interface_control_two;
         lics_pkg::IDX_LINE_INTERFACE_CONTROL_THREE: rd_mux = s.line_interface_control_three;
         lics_pkg::IDX_LINE_INTERFACE_CONTROL_FOUR: rd_mux = s.line_interface_control_four;
         lics_pkg::IDX_TGAIN: rd_mux = s.tgain;
         default: begin
            rd_mux = 8'h00;
            hit = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.ready = setup;
      next_s.err = setup & ~hit;
      if (setup) begin
         next_s.rdata = hit ? rd_mux : 8'h00;
      end
      next_s.rst_pulse = 1'b0;
      next_s.bpv_pulse = 1'b0;
      if (wr) begin
         case (idx)
            lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO: begin
               next_s.line_interface_control_two = wd & lics_pkg::WMASK_LINE_INTERFACE_CONTROL_TWO;
               // Only a 0-to-1 write triggers; holding the bit at 1 does not
               next_s.rst_pulse = wd[lics_pkg::B_LINE_RESET]
                  & ~s.line_interface_control_two[lics_pkg::B_LINE_RESET];
               next_s.bpv_pulse = wd[lics_pkg::B_VIOLATION_INSERT]
                  & ~s.line_interface_control_two[lics_pkg::B_VIOLATION_INSERT];
            end
            lics_pkg::IDX_LINE_INTERFACE_CONTROL_THREE: next_s.line_interface_control_three = wd & lics_pkg::WMASK_LINE_INTERFACE_CONTROL_THREE;
            lics_pkg::IDX_LINE_INTERFACE_CONTROL_FOUR: next_s.line_interface_control_four = wd & lics_pkg::WMASK_LINE_INTERFACE_CONTROL_FOUR;
            lics_pkg::IDX_TGAIN: next_s.tgain = wd & lics_pkg::WMASK_TGAIN;
            lics_pkg::IDX_MASK: next_s.mask = wd & lics_pkg::WMASK_MASK;
            default: next_s.line_interface_control_two = s.line_interface_control_two;
         endcase
      end
      next_s.lim_on = ~next_s.line_interface_control_two[lics_pkg::B_SHORT_LIMIT_DISABLE];
      next_s.cond_q = {limit_c, open_c};
      next_s.trip_q = trip;
      // A new event in the reading cycle survives the clear
      next_s.attenuator_trip = (s.attenuator_trip & ~rd_status) | trip_rise;
      next_s.pend = (s.pend & {3{~rd_status}})
         | {trip_rise, {limit_c, open_c} ^ s.cond_q};
      next_s.irq = |(s.pend & {s.mask[lics_pkg::B_ATTENUATOR_TRIP],
         s.mask[lics_pkg::B_TX_CURRENT_LIMIT], s.mask[lics_pkg::B_TX_OPEN_CIRCUIT]});
      next_s.gain = s.tgain[lics_pkg::B_AGC] ? s.tgain[5:0] : agc_gain;
      next_s.rterm = lics_pkg::lics_term_dec(
         s.line_interface_control_four[lics_pkg::B_RT_LO +: 3]);
      next_s.tterm = lics_pkg::lics_term_dec(
         s.line_interface_control_four[lics_pkg::B_TT_LO +: 3]);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.line_interface_control_two <= lics_pkg::REG_RESET;
         s.line_interface_control_three <= lics_pkg::REG_RESET;
         s.line_interface_control_four <= lics_pkg::REG_RESET;
         s.tgain <= lics_pkg::REG_RESET;
         s.mask <= lics_pkg::REG_RESET;
         // Limiter stays enabled out of reset, the safe state for the driver
         s.lim_on <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign lk.ais_n = s.line_interface_control_two[lics_pkg::B_AIS];
   assign lk.alt = s.line_interface_control_three[lics_pkg::B_ALTERNATING_PATTERN_TX];
   assign lk.cmi_on = s.line_interface_control_three[lics_pkg::B_CMI_MODE_ON];
   assign lk.cmi_inv = s.line_interface_control_three[lics_pkg::B_CMI_POLARITY_INVERT];
   assign lk.custom = s.line_interface_control_two[lics_pkg::B_CUSTOM_DRIVER_SELECT];
   assign lk.bpv_arm = s.bpv_pulse;
   assign lk.build_out = build_out;

   assign prdata = {24'h000000, s.rdata};
   assign pready = s.ready;
   assign pslverr = s.err;
   assign tx_line_pos = lk.pos;
   assign tx_line_pos_oe = lk.pos_oe;
   assign tx_line_neg = lk.neg;
   assign tx_line_neg_oe = lk.neg_oe;
   assign tx_gain_level = s.gain;
   assign current_limit_on = s.lim_on;
   // Selects drive the PLLs whether or not the attenuator is in use
   assign pll_t1_on = s.line_interface_control_two[lics_pkg::B_CKS0];
   assign pll_e1_on = s.line_interface_control_two[lics_pkg::B_CKS1];
   assign prescale = s.line_interface_control_four[lics_pkg::B_MPS_LO +: 2];
   assign rx_boost_sel = s.line_interface_control_three[lics_pkg::B_MM_LO +: 2];
   assign line_reset_pulse = s.rst_pulse;
   assign cmi_mode_on = s.line_interface_control_three[lics_pkg::B_CMI_MODE_ON];
   assign cmi_rx_invert = s.line_interface_control_three[lics_pkg::B_CMI_POLARITY_INVERT];
   assign rx_term_sel = s.rterm;
   assign tx_term_sel = s.tterm;
   assign line_irq = s.irq;

   AST_GAIN_MANUAL: assert property (@(posedge clock) disable iff (rst)
      s.tgain[lics_pkg::B_AGC] |=> tx_gain_level == $past(s.tgain[5:0]))
      else $error("manual gain not applied");
   AST_GAIN_AUTO: assert property (@(posedge clock) disable iff (rst)
      !s.tgain[lics_pkg::B_AGC] |=> tx_gain_level == $past(agc_gain))
      else $error("automatic gain not applied");
   AST_LIMIT_CTRL: assert property (@(posedge clock) disable iff (rst)
      wr && idx == lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO |=> current_limit_on == !$past(wd[1]))
      else $error("current limiter control wrong");
   AST_PLL_SEL: assert property (@(posedge clock) disable iff (rst)
      wr && idx == lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO
      |=> pll_t1_on == $past(wd[3]) && pll_e1_on == $past(wd[7]))
      else $error("PLL select wrong");
   AST_RESET_RISE: assert property (@(posedge clock) disable iff (rst)
      wr && idx == lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO && wd[6] && !s.line_interface_control_two[6]
      |=> line_reset_pulse ##1 !line_reset_pulse)
      else $error("line reset not one pulse");
   AST_RESET_HOLD: assert property (@(posedge clock) disable iff (rst)
      wr && idx == lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO && s.line_interface_control_two[6] |=> !line_reset_pulse)
      else $error("line reset repeated without clear");
   AST_TERM_OFF: assert property (@(posedge clock) disable iff (rst)
      s.line_interface_control_four[2:0] > 3'h4 && $stable(s.line_interface_control_four) |=> rx_term_sel == 4'h0)
      else $error("receive termination not disabled");
   AST_TRIP_SET: assert property (@(posedge clock) disable iff (rst)
      trip_rise |=> s.attenuator_trip ##1 status[lics_pkg::B_ATTENUATOR_TRIP] || $past(rd_status))
      else $error("trip flag not set");
   AST_TRIP_CLEAR: assert property (@(posedge clock) disable iff (rst)
      rd_status && !trip_rise |=> !s.attenuator_trip)
      else $error("trip flag not cleared by read");
   AST_IRQ_MASKED: assert property (@(posedge clock) disable iff (rst)
      s.mask == 8'h00 |=> !line_irq)
      else $error("masked interrupt raised");
   AST_IRQ_EDGE: assert property (@(posedge clock) disable iff (rst)
      $fell(open_c) && s.mask[1] && !rd_status |=> ##1 line_irq)
      else $error("falling open edge gave no interrupt");
   AST_APB_READY: assert property (@(posedge clock) disable iff (rst)
      setup |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");
   COV_LINE_RESET: cover property (@(posedge clock) disable iff (rst)
      line_reset_pulse);
   COV_TRIP_READ: cover property (@(posedge clock) disable iff (rst)
      s.attenuator_trip ##1 rd_status);
   COV_BAD_ADDR: cover property (@(posedge clock) disable iff (rst)
      pready && pslverr);
   COV_IRQ: cover property (@(posedge clock) disable iff (rst)
      $rose(line_irq));
endmodule
`default_nettype wire

/* verif/lics_line_model.sv */
// Purpose: Behavioural far end of the line: receive level and line conditions
// Assumes: Condition pins are asynchronous to the register clock
// Notes: slow adds three cycles of latency to every condition change
`timescale 1ns/1ns
`default_nettype none
module lics_line_model (
   input wire logic clock,
   input wire logic slow,
   input wire logic [3:0] level_req,
   input wire logic open_req,
   input wire logic limit_req,
   input wire logic trip_req,
   input wire logic pos,
   input wire logic pos_oe,
   input wire logic neg,
   input wire logic neg_oe,
   output logic [3:0] rx_level_pin,
   output logic tx_open_pin,
   output logic tx_limit_pin,
   output logic atten_trip_pin,
   output logic [1:0] sym
);
   logic [6:0] req, d1, d2, d3, pins;
   assign req = {level_req, open_req, limit_req, trip_req};
   initial pins = 7'h00;
   always @(posedge clock) begin
      d1 <= req;
      d2 <= d1;
      d3 <= d2;
   end
   // Moved off the edge: the real line bears no phase relation to our clock
   always @(posedge clock) pins <= #3 (slow ? d3 : req);
   assign rx_level_pin = pins[6:3];
   assign tx_open_pin = pins[2];
   assign tx_limit_pin = pins[1];
   assign atten_trip_pin = pins[0];
   // A mark is a driven high level; an undriven pin never counts as one
   assign sym = {pos & pos_oe, neg & neg_oe};
endmodule
`default_nettype wire

/* verif/test_line_interface_control_status.sv */
// Purpose: Self-checking bench for the line interface register block
// Assumes: Condition pins pass a two-flop synchroniser
// Notes: Line symbols are sampled one cycle after each bit strobe
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_line_interface_control_status;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, er, slow;
   logic tx_bit, tx_bit_valid, tx_mid, open_req, limit_req, trip_req;
   logic tx_open_pin, tx_limit_pin, atten_trip_pin, line_irq, line_reset_pulse;
   logic tx_line_pos, tx_line_pos_oe, tx_line_neg, tx_line_neg_oe;
   logic current_limit_on, pll_t1_on, pll_e1_on, cmi_mode_on, cmi_rx_invert;
   logic [7:0] paddr, rd;
   logic [31:0] pwdata, prdata;
   logic [2:0] build_out;
   logic [5:0] agc_gain, tx_gain_level;
   logic [3:0] rx_level_pin, level_req, rx_term_sel, tx_term_sel;
   logic [1:0] prescale, rx_boost_sel, sym;
   logic [1:0] s [8];
   logic [1:0] oe [8];
   logic pr [8];
   logic [5:0] wi [5];
   logic [7:0] wm [5];
   int fails, comparisons, pulses;

   lics_top dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .tx_bit, .tx_bit_valid, .tx_mid, .build_out, .agc_gain,
      .rx_level_pin, .tx_open_pin, .tx_limit_pin, .atten_trip_pin, .tx_line_pos,
      .tx_line_pos_oe, .tx_line_neg, .tx_line_neg_oe, .tx_gain_level, .current_limit_on,
      .pll_t1_on, .pll_e1_on, .prescale, .rx_boost_sel, .line_reset_pulse, .cmi_mode_on,
      .cmi_rx_invert, .rx_term_sel, .tx_term_sel, .line_irq);
   lics_line_model line (.clock, .slow, .level_req, .open_req, .limit_req, .trip_req,
      .pos(tx_line_pos), .pos_oe(tx_line_pos_oe), .neg(tx_line_neg),
      .neg_oe(tx_line_neg_oe), .rx_level_pin, .tx_open_pin, .tx_limit_pin,
      .atten_trip_pin, .sym);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) if (line_reset_pulse === 1'b1) pulses <= pulses + 1;

   function automatic logic [3:0] tdec(input int c);
      return (c >= 1 && c <= 4) ? 4'(1 << (c - 1)) : 4'h0;
   endfunction
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic waitn(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   // Ready is sampled at the rising edge; the request stands until then
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
      output logic [7:0] r, output logic e);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) fails++;
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      apb(1'b1, {idx, 2'b00}, d, r, e);
   endtask
   task automatic rchk(input string nm, input logic [5:0] idx, input logic [7:0] x);
      logic [7:0] r;
      logic e;
      apb(1'b0, {idx, 2'b00}, 8'h00, r, e);
      `CHK(nm, x, r)
      `CHK(nm, 1'b0, e)
   endtask
   task automatic burst(input logic b, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         tx_bit <= b;
         tx_bit_valid <= 1'b1;
         @(posedge clock);
         tx_bit_valid <= 1'b0;
         @(negedge clock);
         s[i] = sym;
         pr[i] = tx_line_pos;
         oe[i] = {tx_line_pos_oe, tx_line_neg_oe};
         @(posedge clock);
         tx_mid <= 1'b1;
         @(posedge clock);
         tx_mid <= 1'b0;
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #400000;
      fails++;
      give_verdict();
   end

   initial begin
      {rst, psel, penable, pwrite, tx_bit, tx_bit_valid, tx_mid} = 7'h40;
      {slow, open_req, limit_req, trip_req, paddr, pwdata} = 44'h0;
      {build_out, agc_gain, level_req} = 13'h0;
      wi = '{lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, lics_pkg::IDX_LINE_INTERFACE_CONTROL_THREE, lics_pkg::IDX_LINE_INTERFACE_CONTROL_FOUR,
         lics_pkg::IDX_TGAIN, lics_pkg::IDX_MASK};
      wm = '{8'hFB, 8'hD9, 8'hFF, 8'h7F, 8'h16};
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      agc_gain <= 6'h15;
      for (int i = 0; i < 5; i++) rchk("reset value", wi[i], 8'h00);
      rchk("status reset", lics_pkg::IDX_STATUS, 8'h00);
      `CHK("limiter after reset", 1'b1, current_limit_on)
      apb(1'b0, 8'h00, 8'h00, rd, er);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 8'h00, rd)
      apb(1'b1, {lics_pkg::IDX_LINE_INTERFACE_CONTROL_FOUR, 2'b01}, 8'hFF, rd, er);
      `CHK("misaligned err", 1'b1, er)
      rchk("misaligned dropped", lics_pkg::IDX_LINE_INTERFACE_CONTROL_FOUR, 8'h00);
      wreg(lics_pkg::IDX_INFO, 8'hFF);
      rchk("level read only", lics_pkg::IDX_INFO, 8'h00);
      for (int i = 0; i < 5; i++) wreg(wi[i], wm[i]);
      for (int i = 0; i < 5; i++) rchk("unused bits", wi[i], wm[i]);
      `CHK("t1 pll", 1'b1, pll_t1_on)
      `CHK("e1 pll", 1'b1, pll_e1_on)
      `CHK("limiter off", 1'b0, current_limit_on)
      `CHK("cmi on", 1'b1, cmi_mode_on)
      `CHK("cmi invert", 1'b1, cmi_rx_invert)
      `CHK("manual gain", 6'h3F, tx_gain_level)
      `CHK("reset pulses", 1, pulses)
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, 8'hFB);
      wreg(lics_pkg::IDX_TGAIN, 8'h2A);
      waitn(2);
      `CHK("no second reset", 1, pulses)
      `CHK("auto gain", 6'h15, tx_gain_level)
      wreg(lics_pkg::IDX_TGAIN, 8'h6A);
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, 8'h00);
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, 8'h40);
      waitn(2);
      `CHK("manual gain", 6'h2A, tx_gain_level)
      `CHK("rearmed reset", 2, pulses)
      `CHK("limiter on", 1'b1, current_limit_on)
      `CHK("t1 pll off", 1'b0, pll_t1_on)
      `CHK("e1 pll off", 1'b0, pll_e1_on)
      for (int c = 0; c < 8; c++) begin
         wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_FOUR, {2'(c), 3'(7 - c), 3'(c)});
         wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_THREE, {2'(c >> 1), 1'b0, 2'(c), 3'h0});
         waitn(2);
         `CHK("rx term", tdec(c), rx_term_sel)
         `CHK("tx term", tdec(7 - c), tx_term_sel)
         `CHK("prescale", 2'(c), prescale)
         `CHK("boost", 2'(c), rx_boost_sel)
         `CHK("cmi", 1'(c >> 2), cmi_mode_on)
         `CHK("cmi invert", 1'(c >> 1), cmi_rx_invert)
      end
      for (int i = 0; i < 4; i++) begin
         slow <= i[0];
         level_req <= 4'(i * 5);
         idle(12);
         rchk("rx level", lics_pkg::IDX_INFO, 8'(i * 5));
      end
      wreg(lics_pkg::IDX_MASK, 8'h16);
      open_req <= 1'b1;
      waitn(12);
      `CHK("open rise irq", 1'b1, line_irq)
      rchk("open status", lics_pkg::IDX_STATUS, 8'h02);
      waitn(2);
      `CHK("irq cleared", 1'b0, line_irq)
      @(posedge clock);
      open_req <= 1'b0;
      waitn(12);
      `CHK("open fall irq", 1'b1, line_irq)
      rchk("open gone", lics_pkg::IDX_STATUS, 8'h00);
      wreg(lics_pkg::IDX_MASK, 8'h00);
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, 8'h02);
      limit_req <= 1'b1;
      waitn(12);
      `CHK("masked irq", 1'b0, line_irq)
      rchk("limit status", lics_pkg::IDX_STATUS, 8'h04);
      wreg(lics_pkg::IDX_MASK, 8'h10);
      limit_req <= 1'b0;
      trip_req <= 1'b1;
      idle(4);
      trip_req <= 1'b0;
      waitn(10);
      `CHK("trip irq", 1'b1, line_irq)
      rchk("trip status", lics_pkg::IDX_STATUS, 8'h10);
      rchk("trip cleared", lics_pkg::IDX_STATUS, 8'h00);
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_THREE, 8'h00);
      // The first control write already armed a violation
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, 8'h10);
      burst(1'b1, 3);
      `CHK("armed by first write", s[1], s[2])
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, 8'h00);
      burst(1'b0, 4);
      for (int i = 1; i < 4; i++) `CHK("alarm ones", 2'b11, s[i] ^ s[i - 1])
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, 8'h10);
      burst(1'b0, 2);
      `CHK("data zero", 2'b00, s[0] | s[1])
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_THREE, 8'h01);
      burst(1'b1, 4);
      for (int i = 1; i < 4; i++) `CHK("alternate", 1'b1, (|s[i]) ^ (|s[i - 1]))
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_THREE, 8'h80);
      burst(1'b1, 3);
      for (int i = 1; i < 3; i++) `CHK("cmi ones", 1'b1, pr[i] ^ pr[i - 1])
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_THREE, 8'hC0);
      burst(1'b0, 1);
      `CHK("cmi zero inverted", 1'b1, pr[0])
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_THREE, 8'h00);
      burst(1'b0, 1);
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, 8'h30);
      burst(1'b1, 4);
      `CHK("ami before", 2'b11, s[0] ^ s[1])
      `CHK("violation", s[1], s[2])
      `CHK("single violation", 2'b11, s[3] ^ s[2])
      wreg(lics_pkg::IDX_LINE_INTERFACE_CONTROL_TWO, 8'h11);
      burst(1'b0, 3);
      for (int i = 1; i < 3; i++) `CHK("square", 1'b1, pr[i] ^ pr[i - 1])
      build_out <= 3'h2;
      burst(1'b0, 1);
      `CHK("drain idle", 2'b00, oe[0])
      burst(1'b1, 1);
      `CHK("drain mark", 1'b1, ^oe[0])
      give_verdict();
   end
endmodule
`default_nettype wire
